// *** vcr_defines.svh ***
// Constants for the vector processor operating register set
`ifndef VCR_DEFINES_SVH
`define VCR_DEFINES_SVH

`define AREG_W 24
`define SREG_W 64
`define AREG_NUM 8
`define BREG_NUM 64
`define SREG_NUM 8
`define TREG_NUM 64
`define VREG_NUM 8
`define VELEM_NUM 64
`define VL_W 7
`define VL_MIN 7'h01
`define VL_MAX 7'h40
`define VL_RESET 7'h40
`define AREG_RESET 24'h00_0000
`define SREG_RESET 64'h0000_0000_0000_0000
`define MASK_RESET 64'h0000_0000_0000_0000
`define CTX_WORDS 16
`define CTX_S_BIT 3

`endif

// *** vcr_pkg.sv ***
// Types shared by the operating register set modules
`include "vcr_defines.svh"
package vcr_pkg;
    typedef logic [`AREG_W-1:0] a_word_t;
    typedef logic [`SREG_W-1:0] s_word_t;
    typedef logic [`VL_W-1:0] vlen_t;
    typedef logic [5:0] elem_idx_t;
    typedef enum logic [0:0] {SEQ_IDLE, SEQ_RUN} seq_state_t;
endpackage

// *** elem_seq_if.sv ***
// Control and status of one vector element sequencer
`timescale 1ns/1ps
interface elem_seq_if;
    import vcr_pkg::*;
    logic start;
    logic step;
    vlen_t len;
    elem_idx_t idx;
    logic active;
    logic last;
    modport driver (output start, output step, output len, input idx, input active, input last);
    modport seq (input start, input step, input len, output idx, output active, output last);
endinterface

// *** elem_sequencer.sv ***
// Walks element indices from zero up to one below the captured vector length
`timescale 1ns/1ps
`include "vcr_defines.svh"
module elem_sequencer
    import vcr_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    elem_seq_if.seq sq
);
    seq_state_t state;
    vlen_t run_len;
    elem_idx_t idx;
    logic at_end;

    // End of the run is the last index below the length
    assign at_end = ({1'b0, idx} == vlen_t'(run_len - `VL_MIN)); // RL14
    assign sq.idx = idx;
    assign sq.active = (state == SEQ_RUN);
    assign sq.last = (state == SEQ_RUN) && at_end;

    // Run state and index, one element per step
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= SEQ_IDLE;
            idx <= 6'h00;
            run_len <= `VL_RESET;
        end else if (sq.start) begin
            state <= SEQ_RUN;
            idx <= 6'h00;
            run_len <= sq.len; // RL9
        end else begin
            case (state)
                SEQ_IDLE: begin
                    idx <= 6'h00;
                end
                SEQ_RUN: begin
                    if (sq.step) begin
                        if (at_end) begin
                            state <= SEQ_IDLE; // RL14
                        end else begin
                            idx <= idx + 6'h01; // RL8
                        end
                    end
                end
                default: begin
                    state <= SEQ_IDLE;
                end
            endcase
        end
    end

    // Stepping, bound and stop checks
    chk_seq_advance: assert property (@(posedge clk) disable iff (!resetn) // RL8
        (state == SEQ_RUN && sq.step && !at_end && !sq.start) |=> idx == $past(idx) + 6'h01)
        else $error("sequencer did not advance one element");
    chk_seq_bound: assert property (@(posedge clk) disable iff (!resetn) // RL14
        (state == SEQ_RUN) |-> ({1'b0, idx} < run_len))
        else $error("element index reached the vector length");
    chk_seq_stop: assert property (@(posedge clk) disable iff (!resetn) // RL9
        (state == SEQ_RUN && sq.step && at_end && !sq.start) |=> state == SEQ_IDLE)
        else $error("sequencer ran past the last element");
endmodule

// *** vector_cpu_operating_registers.sv ***
// Operating registers of one vector processor
// Function
// [RL1] Eight 24-bit address registers serve addressing and counting.
// [RL2] Sixty-four 24-bit intermediate address registers back the address registers.
// [RL3] Eight 64-bit scalar registers serve scalar operations.
// [RL4] Sixty-four 64-bit scalar-save registers are provided.
// [RL5] Scalar-save registers act as a cache, with transfers both ways to scalar registers.
// [RL6] Eight vector registers each hold 64 elements of 64 bits.
// [RL7] An address to intermediate address transfer completes in one clock.
// [RL8] A vector source delivers one element per clock in successive clocks.
// [RL9] A writable length register limits the elements any vector operation handles.
// [RL10] A mask register selects particular vector elements.
// [RL11] Auxiliary and control registers stay out of reach of program instructions.
// [RL12] A context switch saves and restores only address and scalar registers, 16 words.
// [RL13] The mask holds one bit per element, a set bit meaning selected.
// [RL14] The length lies in 1 to 64 and elements at or past it are untouched.
`timescale 1ns/1ps
`include "vcr_defines.svh"
module vector_cpu_operating_registers
    import vcr_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic a_wr_en,
    input wire logic [2:0] a_wr_sel,
    input wire logic [23:0] a_wr_data,
    input wire logic [2:0] a_rd_sel,
    output logic [23:0] a_rd_data,
    input wire logic ab_xfer_en,
    input wire logic ab_dir_b2a,
    input wire logic [2:0] ab_a_sel,
    input wire logic [5:0] ab_b_sel,
    input wire logic s_wr_en,
    input wire logic [2:0] s_wr_sel,
    input wire logic [63:0] s_wr_data,
    input wire logic [2:0] s_rd_sel,
    output logic [63:0] s_rd_data,
    input wire logic st_xfer_en,
    input wire logic st_dir_t2s,
    input wire logic [2:0] st_s_sel,
    input wire logic [5:0] st_t_sel,
    input wire logic vl_wr_en,
    input wire logic [6:0] vl_wr_data,
    output logic [6:0] vector_length_reg,
    input wire logic mask_wr_en,
    input wire logic [63:0] mask_wr_data,
    output logic [63:0] element_select_mask,
    input wire logic vrd_start,
    input wire logic [2:0] vrd_sel,
    output logic vrd_busy,
    output logic vrd_valid,
    output logic [63:0] vrd_data,
    output logic vrd_selected,
    output logic vrd_last,
    input wire logic vwr_start,
    input wire logic [2:0] vwr_sel,
    input wire logic vwr_use_mask,
    input wire logic vwr_valid,
    input wire logic [63:0] vwr_data,
    output logic vwr_busy,
    input wire logic ctx_rd_en,
    input wire logic [3:0] ctx_rd_idx,
    output logic ctx_rd_valid,
    output logic [63:0] ctx_rd_data,
    input wire logic ctx_wr_en,
    input wire logic [3:0] ctx_wr_idx,
    input wire logic [63:0] ctx_wr_data
);
    a_word_t a_reg [`AREG_NUM];
    a_word_t b_reg [`BREG_NUM];
    s_word_t s_reg [`SREG_NUM];
    s_word_t t_reg [`TREG_NUM];
    s_word_t v_reg [`VREG_NUM][`VELEM_NUM];
    vlen_t next_vl;
    logic [2:0] rd_vsel;
    logic [2:0] wr_vsel;
    logic wr_masked;
    logic ctx_a_wr;
    logic ctx_s_wr;
    a_word_t a_pick;
    a_word_t b_pick;
    s_word_t s_pick;
    s_word_t t_pick;

    elem_seq_if rd_seq();
    elem_seq_if wr_seq();

    // Sequencer for vector operand reads, one element each clock
    assign rd_seq.start = vrd_start;
    assign rd_seq.step = 1'b1; // RL8
    assign rd_seq.len = vector_length_reg; // RL9
    elem_sequencer u_rd_seq (
        .clk(clk),
        .resetn(resetn),
        .sq(rd_seq)
    );

    // Sequencer for vector result writes, advancing per arriving result
    assign wr_seq.start = vwr_start;
    assign wr_seq.step = vwr_valid;
    assign wr_seq.len = vector_length_reg; // RL9
    elem_sequencer u_wr_seq (
        .clk(clk),
        .resetn(resetn),
        .sq(wr_seq)
    );

    assign vrd_busy = rd_seq.active;
    assign vwr_busy = wr_seq.active;

    // Context block: words 0-7 address, 8-15 scalar; nothing else is reachable
    assign ctx_a_wr = ctx_wr_en && !ctx_wr_idx[`CTX_S_BIT]; // RL12
    assign ctx_s_wr = ctx_wr_en && ctx_wr_idx[`CTX_S_BIT]; // RL11
    assign a_pick = a_reg[ab_a_sel];
    assign b_pick = b_reg[ab_b_sel];
    assign s_pick = s_reg[st_s_sel];
    assign t_pick = t_reg[st_t_sel];

    // Address registers: restore, then transfer, then direct write
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < `AREG_NUM; i++) begin
                a_reg[i] <= `AREG_RESET; // RL1
            end
        end else if (ctx_a_wr) begin
            a_reg[ctx_wr_idx[2:0]] <= ctx_wr_data[`AREG_W-1:0]; // RL12
        end else if (ab_xfer_en && ab_dir_b2a) begin
            a_reg[ab_a_sel] <= b_pick; // RL7
        end else if (a_wr_en) begin
            a_reg[a_wr_sel] <= a_wr_data;
        end
    end

    // Intermediate address registers, loaded from an address register
    always_ff @(posedge clk) begin
        if (ab_xfer_en && !ab_dir_b2a) begin
            b_reg[ab_b_sel] <= a_pick; // RL2 RL7
        end
    end

    // Scalar registers: restore, then cache transfer, then direct write
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < `SREG_NUM; i++) begin
                s_reg[i] <= `SREG_RESET; // RL3
            end
        end else if (ctx_s_wr) begin
            s_reg[ctx_wr_idx[2:0]] <= ctx_wr_data; // RL12
        end else if (st_xfer_en && st_dir_t2s) begin
            s_reg[st_s_sel] <= t_pick; // RL5
        end else if (s_wr_en) begin
            s_reg[s_wr_sel] <= s_wr_data;
        end
    end

    // Scalar-save registers, loaded from a scalar register
    always_ff @(posedge clk) begin
        if (st_xfer_en && !st_dir_t2s) begin
            t_reg[st_t_sel] <= s_pick; // RL4 RL5
        end
    end

    // Registered read ports for address and scalar registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            a_rd_data <= `AREG_RESET;
            s_rd_data <= `SREG_RESET;
        end else begin
            a_rd_data <= a_reg[a_rd_sel];
            s_rd_data <= s_reg[s_rd_sel];
        end
    end

    // Context save read, one word a clock
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctx_rd_valid <= 1'b0;
            ctx_rd_data <= `SREG_RESET;
        end else begin
            ctx_rd_valid <= ctx_rd_en;
            if (ctx_rd_en) begin
                if (ctx_rd_idx[`CTX_S_BIT]) begin
                    ctx_rd_data <= s_reg[ctx_rd_idx[2:0]]; // RL12
                end else begin
                    ctx_rd_data <= {40'h00_0000_0000, a_reg[ctx_rd_idx[2:0]]}; // RL12
                end
            end
        end
    end

    // Length write is clamped into 1..64
    always_comb begin
        next_vl = vl_wr_data;
        if (vl_wr_data < `VL_MIN) begin
            next_vl = `VL_MIN; // RL14
        end else if (vl_wr_data > `VL_MAX) begin
            next_vl = `VL_MAX; // RL14
        end
    end

    // Length and mask registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            vector_length_reg <= `VL_RESET;
            element_select_mask <= `MASK_RESET;
        end else begin
            if (vl_wr_en) begin
                vector_length_reg <= next_vl; // RL9
            end
            if (mask_wr_en) begin
                element_select_mask <= mask_wr_data; // RL13
            end
        end
    end

    // Operand stream: element data, its mask bit and end marker
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rd_vsel <= 3'h0;
            vrd_valid <= 1'b0;
            vrd_data <= `SREG_RESET;
            vrd_selected <= 1'b0;
            vrd_last <= 1'b0;
        end else begin
            if (vrd_start) begin
                rd_vsel <= vrd_sel;
            end
            vrd_valid <= rd_seq.active; // RL8
            vrd_last <= rd_seq.last;
            if (rd_seq.active) begin
                vrd_data <= v_reg[rd_vsel][rd_seq.idx]; // RL6 RL8
                vrd_selected <= element_select_mask[rd_seq.idx]; // RL10 RL13
            end
        end
    end

    // Result stream: select register and masking at start
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_vsel <= 3'h0;
            wr_masked <= 1'b0;
        end else if (vwr_start) begin
            wr_vsel <= vwr_sel;
            wr_masked <= vwr_use_mask;
        end
    end

    // Vector element storage, written only inside the length, and inside the mask when vwr_use_mask was set at start
    always_ff @(posedge clk) begin
        if (wr_seq.active && vwr_valid && !vwr_start) begin
            if (!wr_masked || element_select_mask[wr_seq.idx]) begin // RL10
                v_reg[wr_vsel][wr_seq.idx] <= vwr_data; // RL6 RL14
            end
        end
    end

    // Transfer, length, stream and context checks
    chk_ab_transfer: assert property (@(posedge clk) disable iff (!resetn) // RL7
        (ab_xfer_en && !ab_dir_b2a) |=> b_reg[$past(ab_b_sel)] == $past(a_pick))
        else $error("address to intermediate transfer took more than one clock");
    chk_ba_transfer: assert property (@(posedge clk) disable iff (!resetn) // RL7
        (ab_xfer_en && ab_dir_b2a && !ctx_a_wr) |=> a_reg[$past(ab_a_sel)] == $past(b_pick))
        else $error("intermediate to address transfer failed");
    chk_st_cache: assert property (@(posedge clk) disable iff (!resetn) // RL5
        (st_xfer_en && !st_dir_t2s) |=> t_reg[$past(st_t_sel)] == $past(s_pick))
        else $error("scalar to scalar-save transfer failed");
    chk_ts_cache: assert property (@(posedge clk) disable iff (!resetn) // RL5
        (st_xfer_en && st_dir_t2s && !ctx_s_wr) |=> s_reg[$past(st_s_sel)] == $past(t_pick))
        else $error("scalar-save to scalar transfer failed");
    chk_vl_range: assert property (@(posedge clk) disable iff (!resetn) // RL14
        vector_length_reg >= `VL_MIN && vector_length_reg <= `VL_MAX)
        else $error("vector length outside 1 to 64");
    chk_vl_write: assert property (@(posedge clk) disable iff (!resetn) // RL9
        vl_wr_en |=> vector_length_reg == $past(next_vl))
        else $error("vector length write not taken");
    chk_rd_stream: assert property (@(posedge clk) disable iff (!resetn) // RL8
        (rd_seq.active && !rd_seq.last) |=> vrd_valid ##1 vrd_valid)
        else $error("operand stream broke before the last element");
    chk_ctx_read: assert property (@(posedge clk) disable iff (!resetn) // RL12
        (ctx_rd_en && !ctx_rd_idx[`CTX_S_BIT]) |=>
        ctx_rd_valid && ctx_rd_data[63:24] == 40'h00_0000_0000)
        else $error("context address word not returned one clock later");
endmodule

// *** fu_model.sv ***
// Functional unit model that hands result elements to a vector register
`timescale 1ns/1ps
module fu_model (
    input wire logic clk,
    input wire logic go,
    input wire logic slow,
    input wire logic [6:0] count,
    input wire logic [63:0] base,
    output logic valid,
    output logic [63:0] data
);
    logic [6:0] sent;
    logic run, tog;
    initial begin
        valid = 1'b0;
        data = '0;
        sent = '0;
        run = 1'b0;
        tog = 1'b0;
    end
    // One element per clock, or every other clock when slow
    always @(posedge clk) begin
        tog <= ~tog;
        if (go) begin
            run <= 1'b1;
            sent <= '0;
            valid <= 1'b0;
        end else if (run && sent < count && (!slow || tog)) begin
            valid <= 1'b1;
            data <= base + 64'(sent);
            sent <= sent + 7'h01;
        end else begin
            valid <= 1'b0;
            data <= ~data;  // Idle lines do not keep the last value
            run <= run && sent < count;
        end
    end
endmodule

// *** vector_cpu_operating_registers_test.sv ***
// Self-checking bench for the operating register set
`timescale 1ns/1ps
module vector_cpu_operating_registers_test;
    import vcr_pkg::*;
    logic clk, resetn, a_wr_en, ab_xfer_en, ab_dir_b2a, s_wr_en, st_xfer_en, st_dir_t2s;
    logic vl_wr_en, mask_wr_en, vrd_start, vrd_busy, vrd_valid, vrd_selected, vrd_last;
    logic vwr_start, vwr_use_mask, vwr_valid, vwr_busy, ctx_rd_en, ctx_rd_valid, ctx_wr_en;
    logic [2:0] a_wr_sel, a_rd_sel, ab_a_sel, s_wr_sel, s_rd_sel, st_s_sel, vrd_sel, vwr_sel;
    logic [5:0] ab_b_sel, st_t_sel;
    logic [23:0] a_wr_data, a_rd_data;
    logic [63:0] s_wr_data, s_rd_data, mask_wr_data, element_select_mask, vrd_data, vwr_data;
    logic [63:0] ctx_rd_data, ctx_wr_data, fu_base, d, h, m, b1, b2;
    logic [6:0] vl_wr_data, vector_length_reg, fu_count;
    logic [3:0] ctx_rd_idx, ctx_wr_idx;
    logic fu_go, fu_slow;
    logic [15:0] rnd;
    logic [63:0] am[8], sm[8];
    int bad_count, checks_done, cyc;

    vector_cpu_operating_registers vector_cpu_operating_registers_inst (
        .clk, .resetn, .a_wr_en, .a_wr_sel, .a_wr_data, .a_rd_sel, .a_rd_data,
        .ab_xfer_en, .ab_dir_b2a, .ab_a_sel, .ab_b_sel, .s_wr_en, .s_wr_sel, .s_wr_data,
        .s_rd_sel, .s_rd_data, .st_xfer_en, .st_dir_t2s, .st_s_sel, .st_t_sel,
        .vl_wr_en, .vl_wr_data, .vector_length_reg, .mask_wr_en, .mask_wr_data,
        .element_select_mask, .vrd_start, .vrd_sel, .vrd_busy, .vrd_valid, .vrd_data,
        .vrd_selected, .vrd_last, .vwr_start, .vwr_sel, .vwr_use_mask, .vwr_valid,
        .vwr_data, .vwr_busy, .ctx_rd_en, .ctx_rd_idx, .ctx_rd_valid, .ctx_rd_data,
        .ctx_wr_en, .ctx_wr_idx, .ctx_wr_data
    );
    fu_model fu_model_inst (.clk, .go(fu_go), .slow(fu_slow), .count(fu_count),
        .base(fu_base), .valid(vwr_valid), .data(vwr_data));

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cycle ceiling against a hung run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [63:0] elem(input logic [63:0] b, input int k);
        return b + 64'(k);
    endfunction
    task automatic r64(output logic [63:0] v);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            v = {v[47:0], rnd};
        end
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Register bus cycles; wr and xf set their own enable and clear the others, rd clears all four
    task automatic wr(input bit s, input logic [2:0] r, input logic [63:0] v);
        {a_wr_sel, s_wr_sel, a_wr_data, s_wr_data} = {r, r, v[23:0], v};
        {a_wr_en, s_wr_en, ab_xfer_en, st_xfer_en} = {!s, s, 2'b00};
        if (s) sm[r] = v; else am[r] = {40'h0, v[23:0]};
        @(negedge clk);
    endtask
    task automatic xf(input bit s, input bit dir, input logic [2:0] r, input logic [5:0] b);
        {ab_a_sel, st_s_sel, ab_b_sel, st_t_sel, ab_dir_b2a, st_dir_t2s} = {r, r, b, b, dir, dir};
        {a_wr_en, s_wr_en, ab_xfer_en, st_xfer_en} = {2'b00, !s, s};
        @(negedge clk);
    endtask
    task automatic rd(input bit s, input logic [2:0] r, input logic [63:0] exp);
        {a_rd_sel, s_rd_sel} = {r, r};
        {a_wr_en, s_wr_en, ab_xfer_en, st_xfer_en} = 4'h0;
        @(negedge clk);
        chk(s ? s_rd_data : {40'h0, a_rd_data}, exp);
    endtask
    task automatic vl(input logic [6:0] v);
        {vl_wr_en, vl_wr_data} = {1'b1, v};
        @(negedge clk);
        vl_wr_en = 1'b0;
        @(negedge clk);
    endtask
    task automatic vwrite(input logic [2:0] v, input logic [6:0] n, input logic [63:0] b,
                          input logic um);
        {vwr_sel, vwr_use_mask, fu_slow, fu_count, fu_base} = {v, um, um, n, b};
        {vwr_start, fu_go} = 2'b11;
        @(negedge clk);
        {vwr_start, fu_go} = 2'b00;
        for (int i = 0; i < 200 && vwr_busy !== 1'b0; i++) @(negedge clk);
        chk(vwr_busy, 0);
    endtask
    task automatic vread(input logic [2:0] v, input logic [6:0] n);
        {vrd_sel, vrd_start} = {v, 1'b1};
        @(negedge clk);
        vrd_start = 1'b0;
        chk(vrd_busy, 1);
        for (int i = 0; i < n + 3; i++) begin
            @(negedge clk);
            chk(vrd_valid, i < n);
            if (i < n) begin
                chk(vrd_data, m[i] ? elem(b2, i) : elem(b1, i));
                chk(vrd_selected, m[i]);
                chk(vrd_last, i == n - 1);
            end
        end
        chk(vrd_busy, 0);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rnd = 16'h0040;
        {resetn, a_wr_en, ab_xfer_en, ab_dir_b2a, s_wr_en, st_xfer_en, st_dir_t2s, vl_wr_en,
            mask_wr_en, vrd_start, vwr_start, vwr_use_mask, ctx_rd_en, ctx_wr_en, fu_go} = '0;
        {a_wr_sel, a_rd_sel, ab_a_sel, s_wr_sel, s_rd_sel, st_s_sel, vrd_sel, vwr_sel} = '0;
        {ab_b_sel, st_t_sel, a_wr_data, s_wr_data, mask_wr_data, ctx_wr_data} = '0;
        {vl_wr_data, ctx_rd_idx, ctx_wr_idx, fu_slow, fu_count, fu_base} = '0;
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        chk(vector_length_reg, 7'h40);
        chk(element_select_mask, 0);
        chk(vrd_busy, 0);
        rd(0, 3'h5, 0);
        rd(1, 3'h2, 0);
        $display("reset test done");
        // Fill, park in the backing set, pull into the neighbour register
        for (int s = 0; s < 2; s++) begin
            for (int r = 0; r < 8; r++) begin
                r64(d);
                wr(s, 3'(r), d);
                rd(s, 3'(r), s ? sm[r] : am[r]);
            end
            for (int r = 0; r < 8; r++) begin
                h = s ? sm[r] : am[r];
                xf(s, 0, 3'(r), 6'(r * 9 + 2));
                xf(s, 1, 3'(r + 1), 6'(r * 9 + 2));
                if (s) sm[(r + 1) % 8] = h; else am[(r + 1) % 8] = h;
                rd(s, 3'(r + 1), h);
            end
        end
        $display("transfer test done");
        // Context words back to back, then a restore of one A and one S word
        for (int i = 0; i < 16; i++) begin
            {ctx_rd_en, ctx_rd_idx} = {1'b1, 4'(i)};
            @(negedge clk);
            chk(ctx_rd_valid, 1);
            chk(ctx_rd_data, i < 8 ? am[i] : sm[i - 8]);
        end
        ctx_rd_en = 1'b0;
        @(negedge clk);
        chk(ctx_rd_valid, 0);
        for (int j = 0; j < 2; j++) begin
            r64(d);
            {ctx_wr_en, ctx_wr_idx, ctx_wr_data} = {1'b1, j ? 4'hd : 4'h2, d};
            // A competing direct write in the same cycle must lose to the restore
            {a_wr_en, s_wr_en, a_wr_sel, s_wr_sel} = {j == 0, j == 1, 3'h2, 3'h5};
            {a_wr_data, s_wr_data} = {~d[23:0], ~d};
            @(negedge clk);
            ctx_wr_en = 1'b0;
            rd(j, j ? 3'h5 : 3'h2, j ? d : {40'h0, d[23:0]});
        end
        $display("context test done");
        vl(7'h00);
        chk(vector_length_reg, 7'h01);
        vl(7'h55);
        chk(vector_length_reg, 7'h40);
        // Full stream, then a masked stream with a stalling unit, then read back
        for (int t = 0; t < 2; t++) begin
            vl(t ? 7'h40 : 7'h05);
            r64(m);
            r64(b1);
            r64(b2);
            {mask_wr_en, mask_wr_data} = {1'b1, m};
            @(negedge clk);
            mask_wr_en = 1'b0;
            chk(element_select_mask, m);
            vwrite(3'(t * 5 + 1), t ? 7'h40 : 7'h05, b1, 1'b0);
            vwrite(3'(t * 5 + 1), t ? 7'h40 : 7'h05, b2, 1'b1);
            vread(3'(t * 5 + 1), t ? 7'h40 : 7'h05);
        end
        $display("vector test done");
        test_done();
    end
endmodule
